// ### calc_engine.sv
`timescale 1ns/1ps
module calc_engine #(
  parameter int W = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] x_i,
  input  wire logic [W-1:0] m_i,
  input  wire logic [W-1:0] c_i,
  output logic      [W-1:0] y_o
);
  // Shared multiplier, one result per start, registered output
  logic [2*W:0] prod;
  logic [2*W+1:0] sum;
  assign prod = (2*W+1)'(x_i) * (2*W+1)'({1'b0, m_i} + (W+1)'(1));
  assign sum  = (2*W+2)'(prod >> W) + (2*W+2)'(c_i)
              - (2*W+2)'({1'b1, {(W-1){1'b0}}});

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      y_o <= '0;
    end else if (start_i) begin
      if (sum[2*W+1])
        y_o <= '0;
      else if (|sum[2*W:W])
        y_o <= '1;
      else
        y_o <= sum[W-1:0];
    end
  end
endmodule

// ### dac_ctrl_pkg.sv
// Behaviour
// - Rising reset edge starts a sequence restoring every input, gain and offset register.
// - Reset sequence lasts 300 us; host writes nothing meanwhile.
// - Reset low alone does nothing; rising edge after at least 30 ns triggers.
// - After reset with clear high outputs sit at ground until write and load.
// - Clear low switches every output buffer to its group signal ground.
// - Loads ignored while clear low; releasing clear restores previous outputs.
// - Clear leaves input registers and all sixteen DAC registers unchanged.
// - Each input, gain or offset write recalculates A or B; busy low meanwhile.
// - Writes accepted while busy low, but no DAC update happens.
// - Busy is shared open-drain; any device holding low delays load for all.
// - Falling load updates outputs; load during busy is stored, applied after busy.
// - Load held low updates outputs each time busy rises.
// - Select register write drives busy low for about 600 ns.
// - A write addresses 1, 2, 8 or 16 channels.
// - Channels processed one by one; busy lasts (n+1)*600 ns plus 300 ns.
// - Load refreshes a DAC register only if its A or B was written since.
// - Updated channel copies A or B as chosen by its select bit.
// - Select 0 takes A, 1 takes B; bits 0 to 7 map group channels.
// - Input A, or gain/offset with select control 0, recomputes A; else B.
package dac_ctrl_pkg;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int RESET_SEQ_US     = 300;
  localparam int RESET_SEQ_CYC    = RESET_SEQ_US * 1000 / CLK_PERIOD_NS;
  localparam int SLOT_NS          = 600;
  localparam int SLOT_CYC         = SLOT_NS / CLK_PERIOD_NS;
  localparam int TAIL_NS          = 300;
  localparam int TAIL_CYC         = TAIL_NS / CLK_PERIOD_NS;
  localparam int MIN_RESET_LOW_NS = 30;
  localparam int MIN_RESET_LOW_CYC =
    (MIN_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_CH           = 16;
  localparam int GROUP_CH         = 8;
  // Write scope codes
  localparam logic [1:0] SCOPE_ONE   = 2'h0;
  localparam logic [1:0] SCOPE_GROUP = 2'h1;
  localparam logic [1:0] SCOPE_PAIR  = 2'h2;
  localparam logic [1:0] SCOPE_ALL   = 2'h3;
  // Register kind codes
  localparam logic [1:0] KIND_INPUT  = 2'h0;
  localparam logic [1:0] KIND_GAIN   = 2'h1;
  localparam logic [1:0] KIND_OFFSET = 2'h2;
  localparam logic [15:0] INPUT_RESET  = 16'h8000;
  localparam logic [15:0] GAIN_RESET   = 16'hFFFF;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [15:0] GROUND_CODE  = 16'h8000;
  localparam logic [15:0] SEL_RESET    = 16'h0000;
endpackage

// ### dac_update_reset_clear_control.sv
`timescale 1ns/1ps
module dac_update_reset_clear_control #(
  parameter int W         = 16,
  parameter int RESET_CYC = dac_ctrl_pkg::RESET_SEQ_CYC
) (
  input  wire logic            mclk_i,
  input  wire logic            reset_i,
  input  wire logic            dev_reset_n_i,
  input  wire logic            output_clear_n_i,
  input  wire logic            load_outputs_n_i,
  input  wire logic            busy_line_i,
  input  wire logic            wr_i,
  input  wire logic [1:0]      wr_kind_i,
  input  wire logic            wr_b_i,
  input  wire logic [1:0]      wr_scope_i,
  input  wire logic [3:0]      wr_ch_i,
  input  wire logic [W-1:0]    wr_data_i,
  input  wire logic            sel_wr_i,
  input  wire logic            sel_grp_i,
  input  wire logic [7:0]      sel_data_i,
  output logic                 busy_oe_o,
  output logic                 busy_o,
  output logic                 reset_busy_o,
  output logic [16*W-1:0]      dac_code_o,
  output logic [15:0]          at_ground_o
);
  localparam int NCH = dac_ctrl_pkg::NUM_CH;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_RESET = 4'b0010,
    ST_CALC  = 4'b0100,
    ST_TAIL  = 4'b1000
  } state_e;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic rst_rise, clr_lvl, ld_lvl, ld_fall, busy_lvl, busy_rise;

  edge_sync u_rst (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(dev_reset_n_i),
    .level_o(), .rise_o(rst_rise), .fall_o());
  edge_sync u_clr (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(output_clear_n_i),
    .level_o(clr_lvl), .rise_o(), .fall_o());
  edge_sync u_ld (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(load_outputs_n_i),
    .level_o(ld_lvl), .rise_o(), .fall_o(ld_fall));
  edge_sync u_bsy (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(busy_line_i),
    .level_o(busy_lvl), .rise_o(busy_rise), .fall_o());

  // ---------------------------------------------------------------
  // Register store
  // ---------------------------------------------------------------
  logic [W-1:0] xa_r [NCH];
  logic [W-1:0] xb_r [NCH];
  logic [W-1:0] ma_r [NCH];
  logic [W-1:0] mb_r [NCH];
  logic [W-1:0] ca_r [NCH];
  logic [W-1:0] cb_r [NCH];
  logic [W-1:0] x2a_r [NCH];
  logic [W-1:0] x2b_r [NCH];
  logic [W-1:0] dac_r [NCH];
  logic [NCH-1:0] pend_a_r, pend_b_r;  // Calc queue
  logic [NCH-1:0] dirty_r;             // Written since last load
  logic [NCH-1:0] sel_r;
  logic [NCH-1:0] live_r;              // Loaded since reset

  state_e       state_r;
  logic [31:0]  cnt_r;
  logic [3:0]   cur_ch_r;
  logic         cur_b_r;
  logic         calc_go_r;
  logic         load_pend_r;

  // Address decode of a write: scope to channel mask
  logic [NCH-1:0] wr_mask;
  always_comb begin
    wr_mask = '0;
    case (wr_scope_i)
      dac_ctrl_pkg::SCOPE_ONE:   wr_mask[wr_ch_i] = 1'b1;
      dac_ctrl_pkg::SCOPE_GROUP: wr_mask = wr_ch_i[3] ? 16'hFF00 : 16'h00FF;
      dac_ctrl_pkg::SCOPE_PAIR:  wr_mask = (16'h0101 << wr_ch_i[2:0]);
      default:                   wr_mask = 16'hFFFF;
    endcase
  end

  wire              in_reset = (state_r == ST_RESET);
  wire              data_wr  = wr_i & ~in_reset;
  wire              sel_wr   = sel_wr_i & ~in_reset;
  wire [NCH-1:0]    pend_all = pend_a_r | pend_b_r;
  wire              have_job = |pend_all;
  wire              local_busy = (state_r == ST_CALC) | (state_r == ST_TAIL);
  // Last busy cycle: drive drops with the sequencer, not one cycle late
  wire              busy_end  = (state_r == ST_TAIL) & (cnt_r == 32'd0) & ~have_job;
  wire              reset_end = in_reset & (cnt_r == 32'd0);

  // Next channel to calculate: lowest pending
  logic [3:0] nxt_ch;
  always_comb begin
    nxt_ch = '0;
    for (int i = NCH - 1; i >= 0; i--)
      if (pend_all[i])
        nxt_ch = 4'(i);
  end
  wire              b_next   = ~pend_a_r[nxt_ch];

  // Shared-line busy level as seen by all devices
  wire line_idle = busy_lvl & ~local_busy & ~busy_oe_o;
  wire load_req  = load_pend_r | ld_fall | (~ld_lvl & busy_rise);
  wire do_load   = line_idle & load_req & clr_lvl & ~in_reset;

  logic [W-1:0] calc_y;
  calc_engine #(.W(W)) u_calc (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .start_i (calc_go_r),
    .x_i     (cur_b_r ? xb_r[cur_ch_r] : xa_r[cur_ch_r]),
    .m_i     (cur_b_r ? mb_r[cur_ch_r] : ma_r[cur_ch_r]),
    .c_i     (cur_b_r ? cb_r[cur_ch_r] : ca_r[cur_ch_r]),
    .y_o     (calc_y)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_r   <= ST_IDLE;
      cnt_r     <= '0;
      cur_ch_r  <= '0;
      cur_b_r   <= 1'b0;
      calc_go_r <= 1'b0;
    end else begin
      calc_go_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (have_job) begin
            state_r   <= ST_CALC;
            cnt_r     <= 32'(dac_ctrl_pkg::SLOT_CYC - 1);
            cur_ch_r  <= nxt_ch;
            cur_b_r   <= b_next;
            calc_go_r <= 1'b1;
          end else if (sel_wr) begin
            // Select write needs no calculation, only one slot of busy
            state_r <= ST_TAIL;
            cnt_r   <= 32'(dac_ctrl_pkg::SLOT_CYC - 1);
          end
        end
        ST_RESET: begin
          if (cnt_r == 0)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r - 32'd1;
        end
        ST_CALC: begin
          if (cnt_r != 0)
            cnt_r <= cnt_r - 32'd1;
          else if (have_job) begin
            cnt_r     <= 32'(dac_ctrl_pkg::SLOT_CYC - 1);
            cur_ch_r  <= nxt_ch;
            cur_b_r   <= b_next;
            calc_go_r <= 1'b1;
          end else begin
            state_r <= ST_TAIL;
            cnt_r   <= 32'(dac_ctrl_pkg::SLOT_CYC + dac_ctrl_pkg::TAIL_CYC - 1);
          end
        end
        ST_TAIL: begin
          if (cnt_r == 0)
            state_r <= have_job ? ST_CALC : ST_IDLE;
          else
            cnt_r <= cnt_r - 32'd1;
        end
        default: state_r <= ST_IDLE;
      endcase
      if (rst_rise) begin
        state_r <= ST_RESET;
        cnt_r   <= 32'(RESET_CYC - 1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-channel registers
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire hit    = data_wr & wr_mask[g];
      wire hit_b  = hit & wr_b_i;
      wire hit_a  = hit & ~wr_b_i;
      wire done_a = calc_go_r & (cur_ch_r == 4'(g)) & ~cur_b_r;
      wire done_b = calc_go_r & (cur_ch_r == 4'(g)) & cur_b_r;
      always_ff @(posedge mclk_i) begin
        if (reset_i || rst_rise) begin
          xa_r[g] <= dac_ctrl_pkg::INPUT_RESET;
          xb_r[g] <= dac_ctrl_pkg::INPUT_RESET;
          ma_r[g] <= dac_ctrl_pkg::GAIN_RESET;
          mb_r[g] <= dac_ctrl_pkg::GAIN_RESET;
          ca_r[g] <= dac_ctrl_pkg::OFFSET_RESET;
          cb_r[g] <= dac_ctrl_pkg::OFFSET_RESET;
          pend_a_r[g] <= 1'b0;
          pend_b_r[g] <= 1'b0;
          dirty_r[g]  <= 1'b0;
          sel_r[g]    <= 1'b0;
          live_r[g]   <= 1'b0;
        end else begin
          if (hit_a && wr_kind_i == dac_ctrl_pkg::KIND_INPUT) xa_r[g] <= wr_data_i;
          if (hit_b && wr_kind_i == dac_ctrl_pkg::KIND_INPUT) xb_r[g] <= wr_data_i;
          if (hit_a && wr_kind_i == dac_ctrl_pkg::KIND_GAIN) ma_r[g] <= wr_data_i;
          if (hit_b && wr_kind_i == dac_ctrl_pkg::KIND_GAIN) mb_r[g] <= wr_data_i;
          if (hit_a && wr_kind_i == dac_ctrl_pkg::KIND_OFFSET) ca_r[g] <= wr_data_i;
          if (hit_b && wr_kind_i == dac_ctrl_pkg::KIND_OFFSET) cb_r[g] <= wr_data_i;
          pend_a_r[g] <= hit_a | (pend_a_r[g] & ~done_a);
          pend_b_r[g] <= hit_b | (pend_b_r[g] & ~done_b);
          // New write wins over a load clearing the flag
          dirty_r[g] <= hit | (dirty_r[g] & ~do_load);
          if (sel_wr && sel_grp_i == (g >= dac_ctrl_pkg::GROUP_CH))
            sel_r[g] <= sel_data_i[g % dac_ctrl_pkg::GROUP_CH];
          if (do_load && dirty_r[g])
            live_r[g] <= 1'b1;
        end
      end
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          x2a_r[g] <= dac_ctrl_pkg::GROUND_CODE;
          x2b_r[g] <= dac_ctrl_pkg::GROUND_CODE;
          dac_r[g] <= dac_ctrl_pkg::GROUND_CODE;
        end else begin
          if (state_r == ST_CALC && cnt_r == 1 && cur_ch_r == 4'(g)) begin
            if (cur_b_r) x2b_r[g] <= calc_y;
            else         x2a_r[g] <= calc_y;
          end
          if (do_load && dirty_r[g])
            dac_r[g] <= sel_r[g] ? x2b_r[g] : x2a_r[g];
        end
      end
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          dac_code_o[g*W +: W] <= dac_ctrl_pkg::GROUND_CODE;
          at_ground_o[g]       <= 1'b1;
        end else begin
          dac_code_o[g*W +: W] <= dac_r[g];
          at_ground_o[g]       <= ~clr_lvl | ~live_r[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Load memory and busy drive
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      load_pend_r  <= 1'b0;
      busy_oe_o    <= 1'b0;
      busy_o       <= 1'b0;
      reset_busy_o <= 1'b0;
    end else begin
      // Stored load waits for shared line; clear discards it
      if (!clr_lvl || do_load)
        load_pend_r <= 1'b0;
      else if (ld_fall)
        load_pend_r <= 1'b1;
      busy_oe_o    <= (local_busy & ~busy_end) | (have_job & ~in_reset)
                    | (sel_wr & ~in_reset);
      busy_o       <= 1'b0;
      reset_busy_o <= (in_reset & ~reset_end) | rst_rise;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_clear_ground: assert property (@(posedge mclk_i) disable iff (reset_i)
    !clr_lvl |=> &at_ground_o) else $error("clear did not ground outputs");
  chk_no_load_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    !clr_lvl |-> !do_load) else $error("load accepted during clear");
  chk_no_load_busy: assert property (@(posedge mclk_i) disable iff (reset_i)
    local_busy |-> !do_load) else $error("load during busy");
  chk_busy_on_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    (data_wr && !rst_rise) |=> ##1 busy_oe_o) else $error("busy not driven");
  chk_sel_busy: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_IDLE && sel_wr && !have_job && !rst_rise) |=> local_busy [*8])
    else $error("select busy too short");
  chk_reset_seq: assert property (@(posedge mclk_i) disable iff (reset_i)
    rst_rise |=> in_reset && xa_r[0] == dac_ctrl_pkg::INPUT_RESET)
    else $error("reset sequence not started");
  chk_clean_keep: assert property (@(posedge mclk_i) disable iff (reset_i)
    (do_load && !dirty_r[0]) |=> $stable(dac_r[0])) else $error("clean channel changed");
  chk_stored_load: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ld_fall && !line_idle && clr_lvl && !rst_rise && !in_reset) |=> load_pend_r)
    else $error("load event lost");

  // Two steps: qualified load, then copy of the selected result
  sequence load_ch9_s;
    do_load && dirty_r[9];
  endsequence
  sequence copy_ch9_s;
    dac_r[9] == ($past(sel_r[9]) ? $past(x2b_r[9]) : $past(x2a_r[9]));
  endsequence
  chk_copy_select: assert property (@(posedge mclk_i) disable iff (reset_i)
    load_ch9_s |=> copy_ch9_s) else $error("load copied wrong result");
  chk_held_load: assert property (@(posedge mclk_i) disable iff (reset_i)
    (busy_rise && !ld_lvl && line_idle && clr_lvl && !in_reset && dirty_r[9])
    |=> copy_ch9_s) else $error("held load missed busy release");
  chk_reset_len: assert property (@(posedge mclk_i) disable iff (reset_i)
    rst_rise |=> reset_busy_o [*8]) else $error("reset sequence too short");
endmodule

// ### dac_update_reset_clear_control_bench.sv
`timescale 1ns/1ps
module dac_update_reset_clear_control_bench;
  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  localparam int RC = 50;
  logic         mclk_i   = 1'b0;
  logic         reset_i  = 1'b1;
  logic         rst_req  = 1'b0;
  logic         ext_hold = 1'b0;
  logic         clr_n    = 1'b1;
  logic         ld_n     = 1'b1;
  logic         wr       = 1'b0;
  logic [1:0]   wr_kind  = 2'h0;
  logic         wr_b     = 1'b0;
  logic [1:0]   wr_scope = 2'h0;
  logic [3:0]   wr_ch    = 4'h0;
  logic [15:0]  wr_data  = 16'h0000;
  logic         sel_wr   = 1'b0;
  logic         sel_grp  = 1'b0;
  logic [7:0]   sel_data = 8'h00;
  logic         dev_reset_n;
  logic         busy_line;
  logic         busy_oe;
  logic         busy_drv;
  logic         reset_busy;
  logic [255:0] dac_code;
  logic [15:0]  at_ground;
  int           err_total   = 0;
  int           check_count = 0;

  always #5 mclk_i = ~mclk_i;

  host_model u_host_model (.mclk_i(mclk_i), .reset_i(reset_i), .rst_req_i(rst_req),
    .ext_hold_i(ext_hold), .busy_oe_i(busy_oe), .dev_reset_n_o(dev_reset_n),
    .busy_line_o(busy_line));

  dac_update_reset_clear_control #(.W(16), .RESET_CYC(RC)) u_dac_update_reset_clear_control (
    .mclk_i(mclk_i), .reset_i(reset_i), .dev_reset_n_i(dev_reset_n),
    .output_clear_n_i(clr_n), .load_outputs_n_i(ld_n), .busy_line_i(busy_line),
    .wr_i(wr), .wr_kind_i(wr_kind), .wr_b_i(wr_b), .wr_scope_i(wr_scope), .wr_ch_i(wr_ch),
    .wr_data_i(wr_data), .sel_wr_i(sel_wr), .sel_grp_i(sel_grp), .sel_data_i(sel_data),
    .busy_oe_o(busy_oe), .busy_o(busy_drv), .reset_busy_o(reset_busy), .dac_code_o(dac_code),
    .at_ground_o(at_ground));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [15:0] code(input int k);
    return dac_code[16*k +: 16];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_n(input int k);
    repeat (k) @(negedge mclk_i);
  endtask

  task automatic tick_guard(inout int n, input int lim);
    @(negedge mclk_i);
    n++;
    if (n > lim) begin
      err_total++;
      conclude();
    end
  endtask

  task automatic wait_line(input logic lvl);
    int n;
    n = 0;
    while (busy_line !== lvl) tick_guard(n, 3000);
  endtask

  task automatic write(input logic [1:0] k, input logic b, input logic [1:0] sc,
                       input logic [3:0] ch, input logic [15:0] d);
    @(posedge mclk_i);
    wr_kind  <= k;
    wr_b     <= b;
    wr_scope <= sc;
    wr_ch    <= ch;
    wr_data  <= d;
    wr       <= 1'b1;
    @(posedge mclk_i);
    wr       <= 1'b0;
  endtask

  task automatic busy_width(input logic [15:0] exp);
    int n;
    wait_line(1'b0);
    n = 0;
    while (busy_line === 1'b0) tick_guard(n, 3000);
    chk(16'(n), exp);
  endtask

  task automatic pulse_ld();
    @(posedge mclk_i);
    ld_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
    ld_n <= 1'b1;
  endtask

  task automatic sel_write(input logic grp, input logic [7:0] d);
    @(posedge mclk_i);
    sel_grp  <= grp;
    sel_data <= d;
    sel_wr   <= 1'b1;
    @(posedge mclk_i);
    sel_wr   <= 1'b0;
    busy_width(16'(dac_ctrl_pkg::SLOT_CYC));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_scopes();
    logic [1:0]  sc [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    logic [15:0] nch [4] = '{16'h1, 16'h8, 16'h2, 16'h10};
    for (int i = 0; i < 4; i++) begin
      write(dac_ctrl_pkg::KIND_INPUT, 1'b0, sc[i], 4'h3, 16'h1234);
      busy_width((nch[i] + 16'h1) * 16'(dac_ctrl_pkg::SLOT_CYC) + 16'h1E);
    end
    chk(code(3), 16'h8000);
    chk(at_ground, 16'hFFFF);
    pulse_ld();
    wait_n(8);
    // Default gain and offset pass the input code through
    chk(code(3), 16'h1234);
    chk(code(12), 16'h1234);
    chk(at_ground, 16'h0000);
  endtask

  task automatic sc_select();
    // Group 0 last: an ignored group bit would make channel 8 take B
    sel_write(1'b1, 8'h00);
    sel_write(1'b0, 8'hFF);
    pulse_ld();
    wait_n(8);
    chk(code(5), 16'h1234);
    write(dac_ctrl_pkg::KIND_INPUT, 1'b1, dac_ctrl_pkg::SCOPE_ONE, 4'h5, 16'h4000);
    wait_line(1'b0);
    pulse_ld();
    wait_n(2);
    chk(code(5), 16'h1234);
    wait_line(1'b1);
    wait_n(8);
    chk(code(5), 16'h4000);
    chk(code(6), 16'h1234);
  endtask

  task automatic sc_clear();
    @(posedge mclk_i);
    clr_n <= 1'b0;
    wait_n(4);
    chk(at_ground, 16'hFFFF);
    write(dac_ctrl_pkg::KIND_INPUT, 1'b0, dac_ctrl_pkg::SCOPE_ONE, 4'h8, 16'h2000);
    wait_line(1'b0);
    wait_line(1'b1);
    pulse_ld();
    wait_n(8);
    chk(code(8), 16'h1234);
    chk(code(5), 16'h4000);
    @(posedge mclk_i);
    clr_n <= 1'b1;
    wait_n(4);
    chk(at_ground, 16'h0000);
  endtask

  task automatic sc_shared();
    @(posedge mclk_i);
    ext_hold <= 1'b1;
    ld_n     <= 1'b0;
    write(dac_ctrl_pkg::KIND_INPUT, 1'b0, dac_ctrl_pkg::SCOPE_ONE, 4'h9, 16'h3000);
    // One-channel busy is 150 cycles; outlast it
    wait_n(170);
    chk(code(8), 16'h1234);
    @(posedge mclk_i);
    ext_hold <= 1'b0;
    wait_n(8);
    chk(code(8), 16'h2000);
    chk(code(9), 16'h3000);
    // Load still held low: the next busy release alone must update
    write(dac_ctrl_pkg::KIND_INPUT, 1'b0, dac_ctrl_pkg::SCOPE_ONE, 4'h9, 16'h3800);
    wait_line(1'b0);
    wait_line(1'b1);
    wait_n(8);
    chk(code(9), 16'h3800);
    chk({15'h0, busy_drv}, 16'h0000);
    @(posedge mclk_i);
    ld_n <= 1'b1;
  endtask

  task automatic sc_devreset();
    int n;
    @(posedge mclk_i);
    rst_req <= 1'b1;
    @(posedge mclk_i);
    rst_req <= 1'b0;
    wait_n(2);
    chk({15'h0, reset_busy}, 16'h0000);
    n = 0;
    while (reset_busy !== 1'b1) tick_guard(n, 20);
    n = 0;
    while (reset_busy === 1'b1) tick_guard(n, 1000);
    chk(16'(n), 16'(RC));
    chk(at_ground, 16'hFFFF);
    // Writes only after the sequence ends
    write(dac_ctrl_pkg::KIND_GAIN, 1'b0, dac_ctrl_pkg::SCOPE_ONE, 4'h8, 16'hFFFF);
    wait_line(1'b0);
    wait_line(1'b1);
    pulse_ld();
    wait_n(8);
    chk(code(8), 16'h8000);
  endtask

  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    wait_n(4);
    chk(code(0), 16'h8000);
    sc_scopes();
    sc_select();
    sc_clear();
    sc_shared();
    sc_devreset();
    conclude();
  end
endmodule

// ### edge_sync.sv
`timescale 1ns/1ps
module edge_sync (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // First stage read only by second stage
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o  = sync_r & ~prev_r;
  assign fall_o  = ~sync_r & prev_r;
endmodule

// ### host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic rst_req_i,
  input  wire logic ext_hold_i,
  input  wire logic busy_oe_i,
  output logic      dev_reset_n_o,
  output logic      busy_line_o
);
  // ----------------------------------------
  // Reset pin pulse and shared busy wire
  // ----------------------------------------
  logic [3:0] low_cnt_r;

  // Pull-up; any party pulling low wins
  assign busy_line_o = ~(busy_oe_i | ext_hold_i);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      low_cnt_r     <= 4'h0;
      dev_reset_n_o <= 1'b1;
    end else if (rst_req_i) begin
      low_cnt_r     <= 4'h4;
      dev_reset_n_o <= 1'b0;
    end else if (low_cnt_r != 4'h0) begin
      low_cnt_r     <= low_cnt_r - 4'h1;
      // 40 ns low, above the minimum pulse
      dev_reset_n_o <= (low_cnt_r == 4'h1);
    end
  end
endmodule
